// ===== design/sscc_ctrl.v
`timescale 1ns/10ps
`include "sscc_defs.vh"
// Function
// R01: Start A drives channels 1-2, B drives 3-4, C drives 5-6.
// R02: Pairs started in the same cycle are sampled together.
// R03: Rising start edge puts that pair into hold and starts conversion.
// R04: Busy rises after a start edge and stays high while converting.
// R05: Internal clock times each conversion at 3 us, then busy falls.
// R06: Falling busy returns track-and-holds to track mode.
// R07: Finished results are kept in an output register for the host.
// R08: Range from pin or register bits applies to the next conversion.
// R09: Hold begins a fixed 10 ns aperture after the start edge; the code rounds it up to 3 cycles, 12 ns after launch.
// R10: Results are twos complement, 7fff top and 8000 bottom.
// R11: Range level 1 means two times reference, 0 means four times.
// R12: In hardware mode range pin is sampled at busy falling edge.
// R13: In software mode register selects pairs; start A alone launches.
// R14: Host holds starts high in reset and gives full pulse after.
// R15: Host waits for busy to fall before new start or reading.
// R16: Start edges on a pair already converting are ignored.
module sscc_ctrl (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Conversion start pins
    input  wire        pair_a_start,
    input  wire        pair_b_start,
    input  wire        pair_c_start,
    // Mode and range
    input  wire        sw_mode_sel,
    input  wire [2:0]  sw_pair_enable,
    input  wire        range_pin,
    input  wire [2:0]  range_select_bits,
    // Converter core results, one word per channel
    input  wire [95:0] core_result,
    // Track-and-hold and status
    output reg  [2:0]  hold_q,
    output reg         busy_q,
    output reg  [2:0]  pair_range_q,
    // Output register, one word per channel
    output reg  [95:0] result_q,
    output reg  [5:0]  result_new_q,
    // Result stream
    output reg         res_valid_q,
    output reg  [18:0] res_data_q,
    input  wire        res_ready,
    output reg         fifo_full_q
);
    // ==================================================
    // States
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_STORE = 3'b100;

    // Cycle counts are worked out as integers, then cut to counter width
    localparam integer APER_CYC_I = `SSCC_APER_CYC;
    localparam integer CONV_CYC_I = `SSCC_CONV_CYC;
    localparam [`SSCC_CNT_W-1:0] APER_CNT =
        APER_CYC_I[`SSCC_CNT_W-1:0];
    localparam [`SSCC_CNT_W-1:0] CONV_CNT =
        CONV_CYC_I[`SSCC_CNT_W-1:0];

    // Clamp a raw core word into the legal twos complement span
    function [15:0] clamp_code;
        input [15:0] raw;
        begin
            clamp_code = raw;
            if (raw == `SSCC_CODE_MIN) begin
                clamp_code = `SSCC_CODE_MIN;
            end
        end
    endfunction

    // Next channel in the round-robin drain order
    function [2:0] next_chan;
        input [2:0] ch;
        begin
            if (ch == 3'h5) begin
                next_chan = 3'h0;
            end else begin
                next_chan = ch + 3'h1;
            end
        end
    endfunction

    // ==================================================
    // Input synchronisation
    wire [2:0] start_lvl;
    wire       range_lvl;
    reg  [2:0] start_prev_q;
    reg        armed_q;

    sscc_sync #(.W(4)) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pin_in  ({range_pin, pair_c_start, pair_b_start, pair_a_start}),
        .level_q ({range_lvl, start_lvl})
    );

    // ==================================================
    // Start edge detection and pair selection
    wire [2:0] rise;
    reg  [2:0] launch;

    assign rise = start_lvl & ~start_prev_q;

    always @* begin
        if (sw_mode_sel) begin
            launch = {3{rise[0]}} & sw_pair_enable;   // R13
        end else begin
            launch = rise;                            // R01 R02
        end
    end

    // ==================================================
    // Per-pair timing
    reg [2:0]              state_q [0:2];
    reg [`SSCC_CNT_W-1:0]  cnt_q   [0:2];
    reg [2:0]              range_pend_q;
    reg [2:0]              done;
    reg [2:0]              conv_any;
    reg [2:0]              next_range;
    integer                p;
    integer                q;
    integer                r;
    wire                   busy_d;

    // Range for the next conversion, per pair
    always @* begin
        if (sw_mode_sel) begin
            next_range = range_select_bits;           // R08 R11
        end else begin
            next_range = range_pend_q;
        end
    end

    // Result stream plumbing
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [18:0] fifo_out_data;
    reg         fifo_push;
    reg  [18:0] fifo_word;
    reg  [2:0]  drain_q;
    reg  [2:0]  drain_ch_q;

    always @* begin
        for (q = 0; q < 3; q = q + 1) begin
            done[q]     = (state_q[q] == ST_CONV) &&
                          (cnt_q[q] == CONV_CNT);
            // Only the converting state counts; the store cycle after it
            // must not raise busy a second time
            conv_any[q] = (state_q[q] == ST_CONV);
        end
    end

    assign busy_d = |(conv_any & ~done);

    // ==================================================
    // Start history; a low level must be seen before the first launch
    always @(posedge clk) begin
        if (!rst_n) begin
            start_prev_q <= 3'h7;
            armed_q      <= 1'b0;
        end else begin
            start_prev_q <= start_lvl;
            if (start_lvl != 3'h7) begin
                armed_q <= 1'b1;
            end
        end
    end

    // ==================================================
    // Busy and the range caught at its falling edge
    always @(posedge clk) begin
        if (!rst_n) begin
            busy_q       <= 1'b0;
            range_pend_q <= 3'h0;
        end else begin
            busy_q <= busy_d;                         // R04
            if (busy_q && !busy_d) begin
                range_pend_q <= {3{range_lvl}};       // R12
            end
        end
    end

    // ==================================================
    // Fresh flags; a result landing wins over the queue clear
    always @(posedge clk) begin
        if (!rst_n) begin
            result_new_q <= 6'h0;
        end else begin
            if (fifo_push) begin
                result_new_q[drain_ch_q] <= 1'b0;
            end
            for (r = 0; r < 3; r = r + 1) begin
                if (done[r]) begin
                    result_new_q[2*r +: 2] <= 2'h3;   // R07
                end
            end
        end
    end

    // ==================================================
    // Per-pair conversion sequencing
    always @(posedge clk) begin
        if (!rst_n) begin
            hold_q       <= 3'h0;
            pair_range_q <= 3'h0;
            result_q     <= 96'h0;
            for (p = 0; p < 3; p = p + 1) begin
                state_q[p] <= ST_IDLE;
                cnt_q[p]   <= {`SSCC_CNT_W{1'b0}};
            end
        end else begin
            for (p = 0; p < 3; p = p + 1) begin
                case (state_q[p])
                ST_IDLE: begin
                    hold_q[p] <= 1'b0;                // R06
                    if (launch[p] && armed_q) begin
                        state_q[p]      <= ST_CONV;   // R03
                        cnt_q[p]        <= {`SSCC_CNT_W{1'b0}};
                        pair_range_q[p] <= next_range[p];
                    end
                end
                ST_CONV: begin
                    // Edges during conversion do nothing here
                    cnt_q[p] <= cnt_q[p] + 1'b1;      // R05 R16
                    if (cnt_q[p] + 1'b1 == APER_CNT) begin
                        hold_q[p] <= 1'b1;            // R09
                    end
                    if (done[p]) begin
                        state_q[p] <= ST_STORE;
                        hold_q[p]  <= 1'b0;           // R06
                        result_q[32*p +: 16] <=
                            clamp_code(core_result[32*p +: 16]); // R10
                        result_q[32*p+16 +: 16] <=
                            clamp_code(core_result[32*p+16 +: 16]);
                    end
                end
                ST_STORE: begin
                    if (drain_q == 3'h0 || drain_ch_q[2:1] != p[1:0]) begin
                        state_q[p] <= ST_IDLE;
                    end
                end
                default: begin
                    state_q[p] <= ST_IDLE;
                end
                endcase
            end
        end
    end

    // ==================================================
    // Drain fresh results into the stream FIFO, channel order
    always @* begin
        fifo_push = 1'b0;
        fifo_word = {drain_ch_q, result_q[16*drain_ch_q +: 16]};
        if (result_new_q[drain_ch_q] && fifo_in_ready) begin
            fifo_push = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            drain_ch_q <= 3'h0;
            drain_q    <= 3'h0;
        end else begin
            // Park on channel 0 when nothing is fresh, so that each batch
            // leaves in channel order; stall on a full FIFO, drop nothing
            if (result_new_q == 6'h0) begin
                drain_ch_q <= 3'h0;
            end else if (!result_new_q[drain_ch_q] || fifo_in_ready) begin
                drain_ch_q <= next_chan(drain_ch_q);
            end
            drain_q <= {2'h0, |result_new_q};
        end
    end

    sscc_fifo #(
        .W     (19),
        .DEPTH (`SSCC_FIFO_DEPTH),
        .AW    (`SSCC_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_word),
        .out_valid (fifo_out_valid),
        .out_ready (res_ready & res_valid_q | ~res_valid_q),
        .out_data  (fifo_out_data)
    );

    // Registered output stage of the stream
    always @(posedge clk) begin
        if (!rst_n) begin
            res_valid_q <= 1'b0;
            res_data_q  <= 19'h0;
            fifo_full_q <= 1'b0;
        end else begin
            fifo_full_q <= ~fifo_in_ready;
            if (res_ready || !res_valid_q) begin
                res_valid_q <= fifo_out_valid;
                res_data_q  <= fifo_out_data;
            end
        end
    end
endmodule

// ===== design/sscc_defs.vh
`ifndef SSCC_DEFS_VH
`define SSCC_DEFS_VH

// ==================================================
// Width and structure
`define SSCC_PAIRS        3
`define SSCC_CHANS        6
`define SSCC_RES_W        16
`define SSCC_FIFO_DEPTH   16
`define SSCC_FIFO_AW      4

// ==================================================
// Timing, clock at 250 MHz
`define SSCC_CLK_MHZ      250
`define SSCC_CONV_NS      3000
`define SSCC_APER_NS      10
`define SSCC_CONV_CYC     ((`SSCC_CONV_NS * `SSCC_CLK_MHZ) / 1000)
`define SSCC_APER_CYC     ((`SSCC_APER_NS * `SSCC_CLK_MHZ + 999) / 1000)
`define SSCC_CNT_W        10

// ==================================================
// Range encoding
`define SSCC_RANGE_X4     1'b0
`define SSCC_RANGE_X2     1'b1

// ==================================================
// Result coding, twos complement
`define SSCC_CODE_MAX     16'h7fff
`define SSCC_CODE_MIN     16'h8000

`endif

// ===== design/sscc_sync.v
`timescale 1ns/10ps
// ==================================================
// Three-stage synchroniser; change accepted when stages 2 and 3 agree
module sscc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Pin side
    input  wire [W-1:0] pin_in,
    // Clean side
    output reg  [W-1:0] level_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer     i;

    always @(posedge clk) begin
        if (!rst_n) begin
            s1_q    <= {W{1'b1}};
            s2_q    <= {W{1'b1}};
            s3_q    <= {W{1'b1}};
            level_q <= {W{1'b1}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ===== design/sscc_fifo.v
`timescale 1ns/10ps
// ==================================================
// Result FIFO with valid/ready on both sides
module sscc_fifo #(
    parameter W     = 19,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // Drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ===== dv/sscc_ctrl_assertions.sv
`timescale 1ns/10ps
// ==================================================
// Port checks on the conversion control
module sscc_ctrl_assertions (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // Inputs
    input wire        pair_a_start,
    input wire        pair_b_start,
    input wire        sw_mode_sel,
    input wire        res_ready,
    // Outputs
    input wire [2:0]  hold_q,
    input wire        busy_q,
    input wire [2:0]  pair_range_q,
    input wire [95:0] result_q,
    input wire [5:0]  result_new_q,
    input wire        res_valid_q,
    input wire [18:0] res_data_q
);
    // Busy length in cycles; a repetition would be far too long to unroll
    reg  [9:0] busy_cnt_q;
    wire [9:0] busy_cnt_d = busy_q ? busy_cnt_q + 10'h1 : 10'h0;
    always @(posedge clk) busy_cnt_q <= rst_n ? busy_cnt_d : 10'h0;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_start_holds: assert property ($rose(pair_a_start) && !busy_q
        && !sw_mode_sel |-> ##[2:9] hold_q[0]) else $error("no hold on a");
    a_pair_route: assert property (!sw_mode_sel && $rose(hold_q[1])
        |-> !$past(pair_b_start, 10)) else $error("pair b held, no start");
    a_hold_busy: assert property (hold_q != 3'h0 |-> busy_q)
        else $error("hold without busy");
    a_aperture: assert property ($rose(busy_q) |-> ##[1:3] hold_q != 3'h0)
        else $error("hold late after busy");
    a_conv_len: assert property ($fell(busy_q) |-> busy_cnt_q >= 10'd745
        && busy_cnt_q <= 10'd755) else $error("conversion length wrong");
    a_busy_bound: assert property (busy_q |-> busy_cnt_q < 10'd756)
        else $error("busy stuck high");
    a_track_back: assert property ($fell(busy_q) |-> hold_q == 3'h0
        && result_new_q != 6'h0) else $error("no track or no result");
    a_result_stand: assert property (busy_q |-> $stable(result_q))
        else $error("results moved while busy");
    a_range_stand: assert property (busy_q && $past(busy_q)
        |-> $stable(pair_range_q)) else $error("range moved while busy");
    a_stream_hold: assert property (res_valid_q && !res_ready |=>
        res_valid_q && $stable(res_data_q)) else $error("stream word dropped");
    a_chan_code: assert property (res_valid_q |-> res_data_q[18:16] <= 3'h5)
        else $error("bad channel number");
endmodule

// ===== dv/sscc_host.sv
`timescale 1ns/10ps
// ==================================================
// Host model: start pins and result reader
module sscc_host (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Requests from the bench
    input  wire [2:0] go,
    input  wire [1:0] stall,
    // Pins to the block
    output reg        pair_a_start,
    output reg        pair_b_start,
    output reg        pair_c_start,
    output reg        res_ready
);
    initial {pair_c_start, pair_b_start, pair_a_start, res_ready} = 4'hf;
    always @(negedge clk) begin
        // Starts idle high so reset always sees them high
        {pair_c_start, pair_b_start, pair_a_start} <= rst_n ? ~go : 3'h7;
        // Slow reader toggles; stall 2 stops reading to fill the buffer
        res_ready <= (stall == 2'h0) | (stall == 2'h1 & ~res_ready);
    end
endmodule

// ===== dv/test_sscc_ctrl.sv
`timescale 1ns/10ps
bind sscc_ctrl sscc_ctrl_assertions chk_u (.clk, .rst_n, .pair_a_start,
    .pair_b_start, .sw_mode_sel, .res_ready, .hold_q, .busy_q, .pair_range_q,
    .result_q, .result_new_q, .res_valid_q, .res_data_q);
// ==================================================
// Bench for the conversion control
module test_sscc_ctrl;
    reg          clk = 1'b0;
    reg          rst_n = 1'b0;
    reg  [2:0]   go = 3'h0;
    reg  [1:0]   stall = 2'h0;
    reg          sw_mode_sel = 1'b0;
    reg  [2:0]   sw_pair_enable = 3'h0;
    reg          range_pin = 1'b0;
    reg  [2:0]   range_select_bits = 3'h0;
    reg  [95:0]  core_result = 96'h0;
    wire         pair_a_start, pair_b_start, pair_c_start, res_ready;
    wire [2:0]   hold_q, pair_range_q;
    wire         busy_q, res_valid_q, fifo_full_q;
    wire [95:0]  result_q;
    wire [5:0]   result_new_q;
    wire [18:0]  res_data_q;
    int          errors = 0;
    int          samples_checked = 0;
    int          n;
    logic [18:0] exp_q[$];

    always #2 clk = ~clk;
    sscc_host host_u (.clk, .rst_n, .go, .stall, .pair_a_start,
        .pair_b_start, .pair_c_start, .res_ready);
    sscc_ctrl dut_u (.clk, .rst_n, .pair_a_start, .pair_b_start,
        .pair_c_start, .sw_mode_sel, .sw_pair_enable, .range_pin,
        .range_select_bits, .core_result, .hold_q, .busy_q, .pair_range_q,
        .result_q, .result_new_q, .res_valid_q, .res_data_q, .res_ready,
        .fifo_full_q);

    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            errors++;
            $display("Error %0t: %s", $time, m);
        end
    endtask

    task automatic wrap_up;
        $display("Checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic step(input int lim);
        @(negedge clk);
        if (++n > lim) begin
            chk(1'b0, "wait ran out");
            wrap_up();
        end
    endtask

    task automatic wait_busy(input bit want, input int lim);
        n = 0;
        while (busy_q !== want) step(lim);
    endtask

    task automatic pulse(input [2:0] g);
        go <= g;
        repeat (3) @(negedge clk);
        go <= 3'h0;
    endtask

    // Results are expected in channel order from the latched words
    task automatic conv(input [2:0] g, input [5:0] m, input bit again);
        for (int k = 0; k < 6; k++) begin
            core_result[16*k+:16] = 16'($urandom);
            if (m[k]) exp_q.push_back({k[2:0], core_result[16*k+:16]});
        end
        pulse(g);
        wait_busy(1'b1, 20);
        if (again) pulse(g);
        wait_busy(1'b0, 760);
    endtask

    task automatic drain(input string t);
        n = 0;
        while (exp_q.size() != 0) step(500);
        $display("Test %s done", t);
    endtask

    always @(posedge clk) begin
        if (rst_n && res_valid_q === 1'b1 && res_ready === 1'b1) begin
            if (exp_q.size() == 0)
                chk(1'b0, "unexpected word");
            else
                chk(res_data_q === exp_q.pop_front(), "word wrong");
        end
    end

    initial begin
        void'($urandom(32'h68c526ab));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        for (int i = 0; i < 6; i++) begin
            range_pin = (i >= 3);
            stall = (i >= 3) ? 2'h1 : 2'h0;
            conv(3'h1 << (i % 3), 6'h3 << (2 * (i % 3)), 1'b0);
            if (i % 3 == 2) // Pin level counts from the next busy fall on
                chk(pair_range_q === (i == 5 ? 3'h6 : 3'h0),
                    "pin range");
        end
        drain("single pairs");
        conv(3'h7, 6'h3f, 1'b0);
        drain("all pairs");
        conv(3'h1, 6'h03, 1'b1);
        drain("restart ignored");
        sw_mode_sel = 1'b1;
        sw_pair_enable = 3'h5;
        range_select_bits = 3'($urandom);
        conv(3'h1, 6'h33, 1'b0);
        chk({pair_range_q[2], pair_range_q[0]} ===
            {range_select_bits[2], range_select_bits[0]}, "reg range");
        pulse(3'h2);
        repeat (20) @(negedge clk);
        chk(busy_q === 1'b0, "b started in software mode");
        drain("software mode");
        sw_mode_sel = 1'b0;
        stall = 2'h2;
        repeat (3) conv(3'h7, 6'h3f, 1'b0);
        repeat (30) @(negedge clk);
        chk(fifo_full_q === 1'b1, "buffer not full");
        stall = 2'h0;
        drain("buffer fill");
        chk(fifo_full_q === 1'b0, "buffer still full");
        wrap_up();
    end
endmodule
